// ==== rtl/efi_pkg.sv ====
// How it works
// - Processor is stalled during program or erase; peripherals keep running.
// - Erase leaves every bit of the page at logic zero.
// - Hardware holds system clock, fetches data from RAM, programs, releases.
// - Array is 32-bit words; the read path returns 32-bit words.
// - 32K bytes as 512 pages of 64 bytes; page is erase/program unit.
// - AHB slave serves instruction and data reads, driving flash read strobes.
// - Reads during program or erase stall, then finish with correct data.
// - Controller switches the internal RC oscillator on for each operation.
// - Program and erase timing runs from internal RC oscillator ticks.
// - Erase works on a single page.
// - Pages 0-479 user code to 0x77FF; pages 480-511 boot loader.
// - Flash is directly addressable memory; each read returns sensed data.
// - Access is restricted by the captured code security level.
// - Bad start address or fill past page end skips it, sets error.
package efi_pkg;
	// ------------------------------------------------------------
	// array geometry
	// ------------------------------------------------------------
	localparam int          WORD_AW         = 13;
	localparam int          PAGE_WORDS      = 16;
	localparam int          PAGES           = 512;
	localparam logic [8:0]  BOOT_FIRST_PAGE = 9'h1E0;
	localparam logic [31:0] USER_LAST_BYTE  = 32'h0000_77FF;
	localparam logic [31:0] BOOT_BASE       = 32'h0000_7800;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ADDR   = 8'h08;
	localparam logic [7:0] OFS_SRC    = 8'h0C;
	localparam logic [7:0] OFS_COUNT  = 8'h10;
	localparam logic [7:0] OFS_MASK   = 8'h14;
	localparam logic [7:0] OFS_SEC    = 8'h18;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_PROG_SEL   = 0;
	localparam int CTRL_PAGE_ERASE = 1;
	localparam int CTRL_START      = 2;
	localparam int CTRL_ERASE_ST   = 3;
	localparam int STAT_BUSY       = 0;
	localparam int STAT_ERR        = 1;
	localparam int STAT_DONE       = 2;
	// ------------------------------------------------------------
	// reset values and timing
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_RST  = 32'h0000_0000;
	localparam logic [4:0]  COUNT_RST = 5'h10;
	localparam logic [2:0]  MASK_RST  = 3'h0;
	localparam logic [3:0]  PROG_TICKS = 4'h4;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : efi_pkg

// ==== rtl/efi_sync3.sv ====
module efi_sync3 (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// asynchronous input and clean results
	input  wire logic d,
	output logic      level,
	output logic      rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic rise;
	} efi_sync_type;

	efi_sync_type st_r;
	efi_sync_type st_nxt;

	// ------------------------------------------------------------
	// three stages; a change counts once stages two and three agree
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.rise = 1'b0;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.lvl = st_r.s3;
			st_nxt.rise = st_r.s3 & ~st_r.lvl;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.lvl;
	assign rise  = st_r.rise;
endmodule : efi_sync3

// ==== rtl/efi_flash_if.sv ====
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
module efi_flash_if #(
	parameter logic [3:0] PROG_TICKS = efi_pkg::PROG_TICKS
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// ahb read port
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// flash macro
	output logic      [12:0] fl_addr,
	output logic             fl_rd,
	output logic             fl_wr,
	output logic      [31:0] fl_wdata,
	input  wire logic [31:0] fl_rdata,
	// ram fetch port
	output logic      [31:0] ram_addr,
	output logic             ram_rd,
	input  wire logic        ram_rvalid,
	input  wire logic [31:0] ram_rdata,
	// oscillator, clock hold, security
	input  wire logic        rc_osc_tick,
	output logic             rc_osc_en,
	output logic             clk_hold,
	input  wire logic [1:0]  cs_strap,
	input  wire logic        dbg_active,
	// axi4-lite register port
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// interrupt
	output logic             irq
);
	typedef enum logic [1:0] {O_IDLE, O_FETCH, O_PROG} efi_op_type;
	typedef enum logic [2:0] {A_IDLE, A_WAIT, A_RD, A_CAP, A_ERR} efi_ahb_type;

	typedef struct packed {
		logic        awready, wready, bvalid, aw_got, w_got;
		logic [1:0]  bresp;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        arready, rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        prog_sel, erase_sel, err, done, cs_taken;
		logic [31:0] fadr, src;
		logic [4:0]  cnt, left;
		logic [2:0]  mask;
		logic [1:0]  cs;
		efi_op_type  op;
		logic [12:0] wadr;
		logic [3:0]  ticks;
		logic        erase_op;
		efi_ahb_type ast;
		logic [12:0] a_wadr;
		logic [31:0] hrdata;
		logic        hreadyout, hresp;
		logic [12:0] fl_addr;
		logic        fl_rd, fl_wr;
		logic [31:0] fl_wdata, ram_addr;
		logic        ram_rd, rc_osc_en, clk_hold, irq;
	} efi_state_type;

	efi_state_type st_r;
	efi_state_type st_nxt;
	logic          tick;
	logic          locked;

	// ------------------------------------------------------------
	// oscillator tick synchroniser
	// ------------------------------------------------------------
	efi_sync3 u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (rc_osc_tick),
		.level   (),
		.rise    (tick)
	);

	assign locked = (st_r.cs != 2'h0) && dbg_active;

	function automatic logic [31:0] wmerge(input logic [31:0] o,
	                                       input logic [31:0] n,
	                                       input logic [3:0]  s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = n[8*i +: 8];
			end
		end
		return r;
	endfunction : wmerge

	// ------------------------------------------------------------
	// next state of registers, operation engine and read path
	// ------------------------------------------------------------
	always_comb begin
		logic [31:0] d;
		logic        go_prog;
		logic        go_erase;
		logic [5:0]  span;
		d = '0;
		go_prog = 1'b0;
		go_erase = 1'b0;
		span = '0;
		st_nxt = st_r;
		st_nxt.fl_rd = 1'b0;
		st_nxt.fl_wr = 1'b0;
		st_nxt.ram_rd = 1'b0;
		// strap captured once after reset release
		if (!st_r.cs_taken) begin
			st_nxt.cs = cs_strap;
			st_nxt.cs_taken = 1'b1;
		end
		// axi write address and data, in either order
		if (awvalid && st_r.awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = awaddr;
		end
		if (wvalid && st_r.wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = wdata;
			st_nxt.wstrb = wstrb;
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end
		// register write once both halves are held
		if (st_nxt.aw_got && st_nxt.w_got && !st_r.bvalid) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = efi_pkg::RESP_OKAY;
			case (st_nxt.awaddr)
				efi_pkg::OFS_CTRL: begin
					d = wmerge('0, st_nxt.wdata, st_nxt.wstrb);
					st_nxt.prog_sel = d[efi_pkg::CTRL_PROG_SEL];
					st_nxt.erase_sel = d[efi_pkg::CTRL_PAGE_ERASE];
					go_prog = d[efi_pkg::CTRL_START] & d[efi_pkg::CTRL_PROG_SEL];
					go_erase = d[efi_pkg::CTRL_ERASE_ST]
					         & d[efi_pkg::CTRL_PAGE_ERASE];
				end
				efi_pkg::OFS_STATUS: begin
					d = wmerge('0, st_nxt.wdata, st_nxt.wstrb);
					if (d[efi_pkg::STAT_ERR]) st_nxt.err = 1'b0;
					if (d[efi_pkg::STAT_DONE]) st_nxt.done = 1'b0;
				end
				efi_pkg::OFS_ADDR:
					st_nxt.fadr = wmerge(st_r.fadr, st_nxt.wdata, st_nxt.wstrb);
				efi_pkg::OFS_SRC:
					st_nxt.src = wmerge(st_r.src, st_nxt.wdata, st_nxt.wstrb);
				efi_pkg::OFS_COUNT: begin
					d = wmerge({27'h0, st_r.cnt}, st_nxt.wdata, st_nxt.wstrb);
					st_nxt.cnt = d[4:0];
				end
				efi_pkg::OFS_MASK: begin
					d = wmerge({29'h0, st_r.mask}, st_nxt.wdata, st_nxt.wstrb);
					st_nxt.mask = {d[2:1], 1'b0};
				end
				efi_pkg::OFS_SEC: ;
				default: st_nxt.bresp = efi_pkg::RESP_SLVERR;
			endcase
		end
		// axi read
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = efi_pkg::RESP_OKAY;
			st_nxt.rdata = '0;
			case (araddr)
				efi_pkg::OFS_CTRL:
					st_nxt.rdata = {30'h0, st_r.erase_sel, st_r.prog_sel};
				efi_pkg::OFS_STATUS:
					st_nxt.rdata = {29'h0, st_r.done, st_r.err,
					                st_r.op != O_IDLE};
				efi_pkg::OFS_ADDR:  st_nxt.rdata = st_r.fadr;
				efi_pkg::OFS_SRC:   st_nxt.rdata = st_r.src;
				efi_pkg::OFS_COUNT: st_nxt.rdata = {27'h0, st_r.cnt};
				efi_pkg::OFS_MASK:  st_nxt.rdata = {29'h0, st_r.mask};
				efi_pkg::OFS_SEC:   st_nxt.rdata = {30'h0, st_r.cs};
				default: st_nxt.rresp = efi_pkg::RESP_SLVERR;
			endcase
		end
		// start checks: size, page end overrun, count
		span = {2'h0, st_r.fadr[5:2]} + {1'b0, st_nxt.cnt};
		if ((go_prog || go_erase) && st_r.op == O_IDLE) begin
			if (st_r.fadr[31:15] != 17'h0 || locked ||
			    (go_prog && (st_nxt.cnt == 5'h0 || span > 6'h10))) begin
				st_nxt.err = 1'b1;
			end else begin
				st_nxt.rc_osc_en = 1'b1;
				st_nxt.clk_hold = 1'b1;
				st_nxt.ticks = PROG_TICKS;
				if (go_erase) begin
					st_nxt.erase_op = 1'b1;
					st_nxt.wadr = {st_r.fadr[14:6], 4'h0};
					st_nxt.left = 5'h10;
					st_nxt.op = O_PROG;
					st_nxt.fl_wr = 1'b1;
					st_nxt.fl_addr = {st_r.fadr[14:6], 4'h0};
					st_nxt.fl_wdata = 32'h0000_0000;
				end else begin
					st_nxt.erase_op = 1'b0;
					st_nxt.wadr = st_r.fadr[14:2];
					st_nxt.left = st_nxt.cnt;
					st_nxt.op = O_FETCH;
					st_nxt.ram_rd = 1'b1;
					st_nxt.ram_addr = st_r.src;
				end
			end
		end
		// operation engine
		case (st_r.op)
			O_IDLE: ;
			O_FETCH: begin
				// data taken from ram by hardware
				if (ram_rvalid) begin
					st_nxt.op = O_PROG;
					st_nxt.fl_wr = 1'b1;
					st_nxt.fl_addr = st_r.wadr;
					st_nxt.fl_wdata = ram_rdata;
					st_nxt.ticks = PROG_TICKS;
				end
			end
			O_PROG: begin
				// word time counted in oscillator ticks
				if (tick) begin
					st_nxt.ticks = st_r.ticks - 4'h1;
				end
				if (tick && st_r.ticks == 4'h1) begin
					if (st_r.left == 5'h1) begin
						st_nxt.op = O_IDLE;
						st_nxt.done = 1'b1;
						st_nxt.rc_osc_en = 1'b0;
						st_nxt.clk_hold = 1'b0;
					end else begin
						st_nxt.left = st_r.left - 5'h1;
						st_nxt.wadr = st_r.wadr + 13'h1;
						st_nxt.ticks = PROG_TICKS;
						if (st_r.erase_op) begin
							st_nxt.fl_wr = 1'b1;
							st_nxt.fl_addr = st_r.wadr + 13'h1;
						end else begin
							st_nxt.op = O_FETCH;
							st_nxt.ram_rd = 1'b1;
							st_nxt.ram_addr = st_r.ram_addr + 32'h4;
						end
					end
				end
			end
			default: st_nxt.op = O_IDLE;
		endcase
		// ahb read path
		case (st_r.ast)
			A_IDLE: begin
				// okay response once an error pair has been shown
				st_nxt.hresp = 1'b0;
				if (hsel && hready && htrans[1]) begin
					st_nxt.a_wadr = haddr[14:2];
					st_nxt.hreadyout = 1'b0;
					st_nxt.hresp = 1'b0;
					// 32K window, user and boot pages alike
					// locked or write access gets an error
					if (hwrite || locked || haddr[31:15] != 17'h0) begin
						st_nxt.hresp = 1'b1;
						st_nxt.ast = A_ERR;
					end else if (st_nxt.op != O_IDLE) begin
						st_nxt.ast = A_WAIT;
					end else begin
						st_nxt.ast = A_RD;
						st_nxt.fl_rd = 1'b1;
						st_nxt.fl_addr = haddr[14:2];
					end
				end
			end
			A_WAIT: begin
				// ready stays low until the operation ends
				if (st_r.op == O_IDLE) begin
					st_nxt.ast = A_RD;
					st_nxt.fl_rd = 1'b1;
					st_nxt.fl_addr = st_r.a_wadr;
				end
			end
			A_RD: st_nxt.ast = A_CAP;
			A_CAP: begin
				st_nxt.hrdata = fl_rdata;
				st_nxt.hreadyout = 1'b1;
				st_nxt.ast = A_IDLE;
			end
			A_ERR: begin
				st_nxt.hreadyout = 1'b1;
				st_nxt.ast = A_IDLE;
			end
			default: st_nxt.ast = A_IDLE;
		endcase
		st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
		st_nxt.arready = !st_nxt.rvalid;
		st_nxt.irq = |({st_nxt.done, st_nxt.err, 1'b0} & st_nxt.mask);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.cnt <= efi_pkg::COUNT_RST;
			st_r.fadr <= efi_pkg::ADDR_RST;
			st_r.mask <= efi_pkg::MASK_RST;
			st_r.op <= O_IDLE;
			st_r.ast <= A_IDLE;
			st_r.hreadyout <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs straight from the state register
	// ------------------------------------------------------------
	assign hrdata    = st_r.hrdata;
	assign hreadyout = st_r.hreadyout;
	assign hresp     = st_r.hresp;
	assign fl_addr   = st_r.fl_addr;
	assign fl_rd     = st_r.fl_rd;
	assign fl_wr     = st_r.fl_wr;
	assign fl_wdata  = st_r.fl_wdata;
	assign ram_addr  = st_r.ram_addr;
	assign ram_rd    = st_r.ram_rd;
	// hold while busy; peripherals are not gated here
	assign clk_hold  = st_r.clk_hold;
	assign rc_osc_en = st_r.rc_osc_en;
	assign awready   = st_r.awready;
	assign wready    = st_r.wready;
	assign bresp     = st_r.bresp;
	assign bvalid    = st_r.bvalid;
	assign arready   = st_r.arready;
	assign rdata     = st_r.rdata;
	assign rresp     = st_r.rresp;
	assign rvalid    = st_r.rvalid;
	assign irq       = st_r.irq;
endmodule : efi_flash_if

// ==== tb/efi_flash_if_chk.sv ====
module efi_flash_if_chk (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// watched outputs and handshakes
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        fl_rd,
	input wire logic        fl_wr,
	input wire logic        ram_rd,
	input wire logic        rc_osc_en,
	input wire logic        clk_hold,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	read_timing_a: assert property (fl_rd |-> !hreadyout ##1
		!hreadyout ##1 hreadyout)
		else $error("flash read answer out of step");
	read_busy_a: assert property (clk_hold |-> !fl_rd)
		else $error("flash read while operation runs");
	osc_hold_a: assert property (clk_hold == rc_osc_en)
		else $error("oscillator enable differs from clock hold");
	prog_held_a: assert property (fl_wr |-> clk_hold)
		else $error("program pulse outside held clock");
	fetch_held_a: assert property (ram_rd |=> clk_hold)
		else $error("ram fetch without held clock");
	tick_pace_a: assert property (fl_wr |=> !fl_wr [*3])
		else $error("program pulses too close");
	ahb_err_a: assert property (hresp && !hreadyout |=>
		hresp && hreadyout)
		else $error("error response not two cycles");
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped early");
	rresp_hold_a: assert property (rvalid && !rready |=>
		rvalid && $stable(rdata))
		else $error("read response dropped early");
	// main scenarios
	cover property (fl_wr);
	cover property (clk_hold && !hreadyout);
	cover property (hresp);
endmodule : efi_flash_if_chk

bind efi_flash_if efi_flash_if_chk u_chk (.aclk, .aresetn, .hreadyout, .hresp,
	.fl_rd, .fl_wr, .ram_rd, .rc_osc_en, .clk_hold, .bvalid, .bready, .rvalid,
	.rready, .rdata);

// ==== tb/efi_far_mdl.sv ====
module efi_far_mdl (
	// clock
	input wire logic        aclk,
	// flash macro
	input wire logic [12:0] fl_addr,
	input wire logic        fl_rd,
	input wire logic        fl_wr,
	input wire logic [31:0] fl_wdata,
	output logic     [31:0] fl_rdata,
	// ram
	input wire logic [31:0] ram_addr,
	input wire logic        ram_rd,
	output logic            ram_rvalid,
	output logic     [31:0] ram_rdata,
	// oscillator
	input wire logic        rc_osc_en,
	output logic            rc_osc_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:8191];
	logic [31:0] adr;
	logic [1:0]  cnt;
	logic        pend, slow;
	// known contents, no reply pending at start
	initial begin
		for (int i = 0; i < 8192; i++)
			mem[i] = 32'h5A00_0000 | i;
		{fl_rdata, ram_rdata, adr} = '0;
		{ram_rvalid, rc_osc_tick, pend, slow, cnt} = '0;
	end
	// word array, data one cycle after strobe, else scrambled
	always @(posedge aclk) begin
		fl_rdata <= fl_rd ? mem[fl_addr] : ~fl_rdata;
		if (fl_wr)
			mem[fl_addr] <= fl_wdata;
	end
	// ram answers promptly and slowly in turn
	always @(posedge aclk) begin
		ram_rvalid <= 1'b0;
		ram_rdata <= ~ram_rdata;
		if (ram_rd) begin
			pend <= 1'b1;
			adr <= ram_addr;
			cnt <= slow ? 2'h2 : 2'h0;
			slow <= ~slow;
		end else if (pend && cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end else if (pend) begin
			pend <= 1'b0;
			ram_rvalid <= 1'b1;
			ram_rdata <= adr ^ 32'h3C3C_0000;
		end
	end
	// oscillator runs only while switched on
	always #7 if (rc_osc_en === 1'b1) rc_osc_tick = ~rc_osc_tick;
endmodule : efi_far_mdl

// ==== tb/tb_efi_flash_if.sv ====
module tb_efi_flash_if;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0, aresetn = 0, hsel = 0, hwrite = 0, hready = 1;
	logic [31:0] haddr = 0, wdata = 0, hrdata, fl_wdata, fl_rdata;
	logic [31:0] ram_addr, ram_rdata, rdata;
	logic [1:0] htrans = 0, cs_strap = 2'h1, bresp, rresp;
	logic [12:0] fl_addr;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic dbg_active = 0, hreadyout, hresp, fl_rd, fl_wr, ram_rd, ram_rvalid;
	logic rc_osc_tick, rc_osc_en, clk_hold, awready, wready, bvalid;
	logic arready, rvalid, irq;
	int mismatches = 0, comparisons = 0, cyc = 0;
	// clock and design under test
	always #2.5 aclk = ~aclk;
	efi_flash_if #(.PROG_TICKS(4'h4)) dut (.aclk, .aresetn, .hsel, .haddr,
		.htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .fl_addr,
		.fl_rd, .fl_wr, .fl_wdata, .fl_rdata, .ram_addr, .ram_rd, .ram_rvalid,
		.ram_rdata, .rc_osc_tick, .rc_osc_en, .clk_hold, .cs_strap,
		.dbg_active, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .irq);
	efi_far_mdl far (.aclk, .fl_addr, .fl_rd, .fl_wr, .fl_wdata, .fl_rdata,
		.ram_addr, .ram_rd, .ram_rvalid, .ram_rdata, .rc_osc_en, .rc_osc_tick);
	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic print_verdict;
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic at, wt, bt;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		bt = 1'b0;
		while (!bt) begin
			#1;
			at = awvalid & awready;
			wt = wvalid & wready;
			bt = bvalid === 1'b1;
			r = bresp;
			@(posedge aclk);
			if (at) awvalid <= 1'b0;
			if (wt) wvalid <= 1'b0;
			if (bt) bready <= 1'b0;
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic at, vt;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		vt = 1'b0;
		while (!vt) begin
			#1;
			at = arvalid & arready;
			vt = rvalid === 1'b1;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (at) arvalid <= 1'b0;
			if (vt) rready <= 1'b0;
		end
	endtask : rd
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		check(d, e);
	endtask : rchk
	task automatic ahb(input logic [31:0] a, input logic w,
		output logic [31:0] d, output logic e);
		logic rdy;
		@(posedge aclk);
		{hsel, htrans, hwrite} <= {1'b1, 2'h2, w};
		haddr <= a;
		@(posedge aclk);
		{hsel, htrans, hwrite} <= '0;
		rdy = 1'b0;
		while (!rdy) begin
			#1;
			rdy = hreadyout === 1'b1;
			d = hrdata;
			e = hresp;
			if (!rdy) @(posedge aclk);
		end
	endtask : ahb
	task automatic fchk(input logic [31:0] a, input logic [31:0] x);
		logic [31:0] d;
		logic e;
		ahb(a, 1'b0, d, e);
		check(d, x);
		check(e, 1'b0);
	endtask : fchk
	// cuts a hang short
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			print_verdict;
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic e;
		static logic [31:0] ea [3] = '{32'h8000, 32'h44, 32'h40};
		static logic [31:0] ec [3] = '{32'h10, 32'h10, 32'h0};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rchk(8'h04, 32'h0);
		rchk(8'h10, 32'h10);
		rchk(8'h18, 32'h1);
		wr(8'h08, 32'h40, r);
		wr(8'h0C, 32'h100, r);
		wr(8'h14, 32'h4, r);
		// no watchdog here; the cycle ceiling bounds the stall
		wr(8'h00, 32'h5, r);
		#1 check(clk_hold, 1'b1);
		fchk(32'h40, 32'h100 ^ 32'h3C3C_0000);
		for (int k = 1; k < 16; k++)
			fchk(32'h40 + 4 * k, (32'h100 + 4 * k) ^ 32'h3C3C_0000);
		#1 check(irq, 1'b1);
		wr(8'h04, 32'h4, r);
		rchk(8'h04, 32'h0);
		check(irq, 1'b0);
		wr(8'h00, 32'hA, r);
		rchk(8'h04, 32'h1);
		d = 32'h1;
		while (d[0]) rd(8'h04, d, r);
		fchk(32'h40, 32'h0);
		fchk(32'h7C, 32'h0);
		fchk(32'h80, 32'h5A00_0020);
		wr(8'h04, 32'h4, r);
		wr(8'h14, 32'h6, r);
		for (int i = 0; i < 3; i++) begin
			wr(8'h08, ea[i], r);
			wr(8'h10, ec[i], r);
			wr(8'h00, 32'h5, r);
			repeat (3) @(posedge aclk);
			#1 check(clk_hold, 1'b0);
			rchk(8'h04, 32'h2);
			check(irq, 1'b1);
			wr(8'h04, 32'h2, r);
		end
		fchk(32'h40, 32'h0);
		fchk(32'h77FC, 32'h5A00_1DFF);
		fchk(32'h7800, 32'h5A00_1E00);
		ahb(32'h0, 1'b1, d, e);
		check(e, 1'b1);
		ahb(32'h8000, 1'b0, d, e);
		check(e, 1'b1);
		rd(8'h40, d, r);
		check(r, 2'h2);
		wr(8'h40, 32'h0, r);
		check(r, 2'h2);
		@(posedge aclk);
		aresetn <= 1'b0;
		dbg_active <= 1'b1;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		wr(8'h08, 32'h0, r);
		wr(8'h00, 32'h5, r);
		rchk(8'h04, 32'h2);
		ahb(32'h0, 1'b0, d, e);
		check(e, 1'b1);
		print_verdict;
	end
endmodule : tb_efi_flash_if
